// ### logic/actuator_ctrl_pkg.sv
// constants and field layouts shared by the actuator control/status block
// assumes a 250 MHz core clock that samples the serial pins
// Operation
// - Status bit 23 always reads as one so an all-zero frame exposes a broken link.
// - A valid frame with control bit 22 set clears every flag of both status words except the not-ready flag at frame end.
// - Control bit 21 alone chooses the overload retry duty; the retry enable sits in bit 18 of the second control word.
// - A supply over- or undervoltage sets status bit 22 or 21 and switches all outputs off.
// - Outputs return by themselves when the supply recovers unless bit 20 is set, then the flags must be cleared.
// - Thermal shutdown sets status bit 20 and holds every output off until that flag is cleared.
// - Status bit 19 reports a temperature warning and never switches an output off.
// - Control bits 19:18 pick the current image: 00 eleven, 10 one or six, 01 five, 11 four, one only if on and six off.
// - Each standby-to-active change sets status bit 18 and blocks outputs until a settle timer ends, then clears it.
// - The not-ready flag is timed by the internal clock so its falling edge can mark test events.
// - Control bit 23 written as zero enters standby and written as one makes the device active.
// - Frame bit 0 picks which control word is written and which status word is shifted out.
package actuator_ctrl_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int STARTUP_TIME_NS = 50000; // charge pump settle time
    localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RETRY_ENABLE_BIT = 18; // position of the retry enable inside control word one

    // status word zero field positions
    localparam int ST_FAULT = 0;
    localparam int ST_ALWAYS_ONE = 23;
    localparam int ST_OVERVOLT = 22;
    localparam int ST_UNDERVOLT = 21;
    localparam int ST_THERMAL = 20;
    localparam int ST_WARNING = 19;
    localparam int ST_NOT_READY = 18;
    localparam logic [23:0] CONTROL_RESET = 24'h000000;
    // synchroniser reset: select high, serial clock, data and all fault inputs at their idle low
    localparam logic [6:0] SYNC_RESET = 7'h40;

    // control word zero layout, bit 23 first
    typedef struct packed {
        logic enable;
        logic status_reset;
        logic retry_duty;
        logic recovery_disable;
        logic [1:0] monitor_sel;
        logic [16:0] switches;
        logic select;
    } control_zero_s;

    typedef enum logic [2:0] {
        MON_ELEVEN = 3'b000,
        MON_ONE = 3'b001,
        MON_SIX = 3'b010,
        MON_FIVE = 3'b011,
        MON_FOUR = 3'b100
    } monitor_src_e;
endpackage

// ### logic/actuator_ctrl_status.sv
// serial-loaded control word zero and status word zero, upper fields, with frame check and start-up timer
// assumes raw pins (frame select, serial clock, data) and analog fault comparators arrive asynchronously
`timescale 1ns/1ps
module actuator_ctrl_status #(
    parameter int startup_cycles = actuator_ctrl_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // serial pins
    input wire logic frame_select_low,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    // analog fault comparators
    input wire logic battery_over_voltage,
    input wire logic battery_under_voltage,
    input wire logic thermal_trip,
    input wire logic thermal_warning,
    // rest of the device
    input wire logic [16:0] overload_flags,
    input wire logic [23:0] status_word_one,
    input wire logic bridge_output_one_on,
    input wire logic bridge_output_six_on,
    output logic status_clear,
    output logic [23:0] control_word_one,
    output logic [16:0] switch_request,
    output logic outputs_allowed,
    output logic device_active,
    output logic overload_retry_enable,
    output logic overload_retry_duty,
    output actuator_ctrl_pkg::monitor_src_e current_monitor_source
);
    localparam int CW = $clog2(startup_cycles + 1);
    // elaboration check: a zero settle time would raise the not-ready flag and never drop it
    if (startup_cycles < 1) begin : g_bad_startup
        $error("startup_cycles must be at least one");
    end

    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic sclk_prev;
    logic csn_prev;
    logic [23:0] shift_in;
    logic [4:0] bit_count;
    logic [23:0] shift_out;
    logic loaded;
    actuator_ctrl_pkg::control_zero_s control_word_zero;
    logic over_flag;
    logic under_flag;
    logic thermal_trip_flag;
    logic warning_flag;
    logic not_ready;
    logic [CW-1:0] settle_count;
    logic [23:0] fault_word_zero;
    logic fault_any;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;
    logic frame_valid;
    logic write_zero;
    logic go_standby;
    logic go_active;
    logic clear_flags;

    // two-flop synchronisers; only the second stage is read
    // reset to idle pin levels, else sticky fault flags would set right after reset
    always_ff @(posedge clock) begin
        if (srst) begin
            sync_a <= actuator_ctrl_pkg::SYNC_RESET;
            sync_b <= actuator_ctrl_pkg::SYNC_RESET;
        end else begin
            sync_a <= {frame_select_low, serial_clock, serial_data_in, battery_over_voltage,
                       battery_under_voltage, thermal_trip, thermal_warning};
            sync_b <= sync_a;
        end
    end

    // edge history on the synchronised serial clock and frame select
    always_ff @(posedge clock) begin
        if (srst) begin
            sclk_prev <= 1'b0;
            csn_prev <= 1'b1;
        end else begin
            sclk_prev <= sync_b[5];
            csn_prev <= sync_b[6];
        end
    end

    assign sclk_rise = sync_b[5] && !sclk_prev && !sync_b[6];
    assign sclk_fall = !sync_b[5] && sclk_prev && !sync_b[6];
    assign frame_start = !sync_b[6] && csn_prev;
    assign frame_end = sync_b[6] && !csn_prev;
    // a frame with any count but exactly 24 clocks is dropped so a glitchy link cannot switch outputs
    assign frame_valid = frame_end && (bit_count == 5'(actuator_ctrl_pkg::FRAME_BITS));
    assign write_zero = frame_valid && !shift_in[0];
    assign go_standby = write_zero && !shift_in[23];
    assign go_active = write_zero && shift_in[23] && !control_word_zero.enable;
    // standby also wipes the flags, since all register bits clear there
    assign clear_flags = (write_zero && shift_in[22]) || (frame_valid && shift_in[0] && shift_in[22])
                         || go_standby;
    assign status_clear = clear_flags;

    // lsb-first input shift and bit counter, saturating one past a full frame
    always_ff @(posedge clock) begin
        if (srst || frame_start) begin
            shift_in <= 24'h000000;
            bit_count <= 5'h00;
        end else if (sclk_rise) begin
            shift_in <= {sync_b[4], shift_in[23:1]};
            if (bit_count != 5'h19) begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    // status word zero, assembled from live flags
    always_comb begin
        fault_word_zero = {6'h00, overload_flags, 1'b0};
        fault_word_zero[actuator_ctrl_pkg::ST_ALWAYS_ONE] = 1'b1;
        fault_word_zero[actuator_ctrl_pkg::ST_OVERVOLT] = over_flag;
        fault_word_zero[actuator_ctrl_pkg::ST_UNDERVOLT] = under_flag;
        fault_word_zero[actuator_ctrl_pkg::ST_THERMAL] = thermal_trip_flag;
        fault_word_zero[actuator_ctrl_pkg::ST_WARNING] = warning_flag;
        fault_word_zero[actuator_ctrl_pkg::ST_NOT_READY] = not_ready;
        fault_any = (|fault_word_zero[22:1]) || (|status_word_one[22:1]);
        fault_word_zero[actuator_ctrl_pkg::ST_FAULT] = fault_any;
    end

    // output shift: the first rising clock loads the word picked by the incoming select bit
    always_ff @(posedge clock) begin
        if (srst || frame_start) begin
            shift_out <= 24'h000000;
            loaded <= 1'b0;
        end else if (sclk_rise && !loaded) begin
            loaded <= 1'b1;
            shift_out <= sync_b[4] ? status_word_one : fault_word_zero;
            shift_out[0] <= fault_any;
        end else if (sclk_fall && loaded) begin
            shift_out <= {1'b0, shift_out[23:1]};
        end
    end

    // before the first clock the data pin polls the fault summary
    always_ff @(posedge clock) begin
        if (srst) begin
            serial_data_out <= 1'b0;
        end else begin
            serial_data_out <= loaded ? shift_out[0] : fault_any;
        end
    end
    assign serial_data_oe = !sync_b[6];

    // control words; standby by a cleared enable clears everything
    always_ff @(posedge clock) begin
        if (srst) begin
            control_word_zero <= actuator_ctrl_pkg::CONTROL_RESET;
            control_word_one <= actuator_ctrl_pkg::CONTROL_RESET;
        end else if (go_standby) begin
            control_word_zero <= actuator_ctrl_pkg::CONTROL_RESET;
            control_word_one <= actuator_ctrl_pkg::CONTROL_RESET;
        end else if (write_zero) begin
            control_word_zero <= shift_in;
        end else if (frame_valid) begin
            control_word_one <= shift_in;
        end
    end

    // sticky supply and thermal flags; a fault present in the clearing cycle stays set
    always_ff @(posedge clock) begin
        if (srst) begin
            over_flag <= 1'b0;
            under_flag <= 1'b0;
            thermal_trip_flag <= 1'b0;
            warning_flag <= 1'b0;
        end else begin
            over_flag <= sync_b[3] || (over_flag && !clear_flags);
            under_flag <= sync_b[2] || (under_flag && !clear_flags);
            thermal_trip_flag <= sync_b[1] || (thermal_trip_flag && !clear_flags);
            warning_flag <= sync_b[0] || (warning_flag && !clear_flags);
        end
    end

    // start-up settle timer on the core clock, so its end is cycle-exact
    always_ff @(posedge clock) begin
        if (srst) begin
            not_ready <= 1'b0;
            settle_count <= '0;
        end else if (go_active) begin
            not_ready <= 1'b1;
            settle_count <= CW'(startup_cycles);
        end else if (go_standby) begin
            not_ready <= 1'b0;
            settle_count <= '0;
        end else if (settle_count != '0) begin
            settle_count <= settle_count - CW'(1);
            not_ready <= (settle_count != CW'(1));
        end
    end

    // output gating; the warning flag deliberately has no say here
    always_ff @(posedge clock) begin
        if (srst) begin
            outputs_allowed <= 1'b0;
        end else begin
            outputs_allowed <= control_word_zero.enable && !not_ready
                && !sync_b[3] && !sync_b[2]
                && !(control_word_zero.recovery_disable && (over_flag || under_flag))
                && !thermal_trip_flag;
        end
    end

    // switch requests only reach the drivers while gating allows
    always_ff @(posedge clock) begin
        if (srst) begin
            switch_request <= 17'h00000;
        end else begin
            switch_request <= outputs_allowed ? control_word_zero.switches : 17'h00000;
        end
    end

    assign device_active = control_word_zero.enable;
    assign overload_retry_enable = control_word_one[actuator_ctrl_pkg::RETRY_ENABLE_BIT];
    assign overload_retry_duty = control_word_zero.retry_duty;

    // current monitor multiplexer select
    always_ff @(posedge clock) begin
        if (srst) begin
            current_monitor_source <= actuator_ctrl_pkg::MON_ELEVEN;
        end else begin
            case (control_word_zero.monitor_sel)
                2'b00: current_monitor_source <= actuator_ctrl_pkg::MON_ELEVEN;
                2'b10: current_monitor_source <= (bridge_output_one_on && !bridge_output_six_on)
                    ? actuator_ctrl_pkg::MON_ONE : actuator_ctrl_pkg::MON_SIX;
                2'b01: current_monitor_source <= actuator_ctrl_pkg::MON_FIVE;
                2'b11: current_monitor_source <= actuator_ctrl_pkg::MON_FOUR;
                default: current_monitor_source <= actuator_ctrl_pkg::MON_ELEVEN;
            endcase
        end
    end
endmodule // actuator_ctrl_status

// ### testbench/actuator_ctrl_status_chk.sv
// port assertions for the actuator control/status block
// assumes one core clock domain and a bind onto the design top
`timescale 1ns/1ps
module actuator_ctrl_status_chk (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // watched ports
    input wire logic frame_select_low,
    input wire logic serial_data_oe,
    input wire logic battery_over_voltage,
    input wire logic battery_under_voltage,
    input wire logic thermal_trip,
    input wire logic status_clear,
    input wire logic [23:0] control_word_one,
    input wire logic [16:0] switch_request,
    input wire logic outputs_allowed,
    input wire logic device_active,
    input wire logic overload_retry_enable
);
    // repetitions leave room for the two sync flops before the gate reacts
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_thermal_off; thermal_trip [*6] |-> !outputs_allowed; endproperty
    a_thermal_off: assert property (p_thermal_off) else $error("drive during thermal trip");
    property p_supply_off; (battery_over_voltage || battery_under_voltage) [*6] |-> !outputs_allowed; endproperty
    a_supply_off: assert property (p_supply_off) else $error("drive during supply fault");
    property p_standby_off; !device_active [*2] |-> !outputs_allowed; endproperty
    a_standby_off: assert property (p_standby_off) else $error("drive in standby");
    property p_settle; $rose(device_active) |-> !outputs_allowed [*8]; endproperty
    a_settle: assert property (p_settle) else $error("drive before settle");
    property p_gate; switch_request != 17'h00000 |-> $past(outputs_allowed); endproperty
    a_gate: assert property (p_gate) else $error("switch without gate");
    property p_clear; status_clear |-> frame_select_low ##1 !status_clear; endproperty
    a_clear: assert property (p_clear) else $error("clear pulse misplaced");
    property p_retry; !$stable(overload_retry_enable) |-> frame_select_low; endproperty
    a_retry: assert property (p_retry) else $error("retry enable moved inside a frame");
    property p_oe_idle; frame_select_low [*3] |-> !serial_data_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data out driven while deselected");
endmodule // actuator_ctrl_status_chk

bind actuator_ctrl_status actuator_ctrl_status_chk u_actuator_ctrl_status_chk (.clock(clock), .srst(srst),
    .frame_select_low(frame_select_low), .serial_data_oe(serial_data_oe), .thermal_trip(thermal_trip),
    .battery_over_voltage(battery_over_voltage), .battery_under_voltage(battery_under_voltage),
    .status_clear(status_clear), .control_word_one(control_word_one), .switch_request(switch_request),
    .outputs_allowed(outputs_allowed), .device_active(device_active), .overload_retry_enable(overload_retry_enable));

// ### testbench/spi_host_model.sv
// host-side serial master for the actuator control block
// assumes mode 0, lsb first, 80 ns bit period timed from the 4 ns core clock
`timescale 1ns/1ps
module spi_host_model (
    // timing clock
    input wire logic clock,
    // serial pins
    output logic frame_select_low,
    output logic serial_clock,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    // idle: deselected, serial clock parked low
    initial begin
        frame_select_low = 1'b1;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    // one frame of n bits; data moves while the serial clock is low
    task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        @(posedge clock) frame_select_low <= 1'b0;
        repeat (10) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            serial_data_in <= tx[i % 24]; // lsb first, bit 0 picks the word
            repeat (10) @(posedge clock);
            rx[i % 24] = serial_data_out;
            serial_clock <= 1'b1;
            repeat (10) @(posedge clock);
            serial_clock <= 1'b0;
        end
        repeat (10) @(posedge clock);
        frame_select_low <= 1'b1;
        serial_data_in <= ~serial_data_in; // a released line must not echo the last bit
        repeat (10) @(posedge clock);
    endtask
endmodule // spi_host_model

// ### testbench/tb_actuator_ctrl_status.sv
// self-checking bench for the actuator control/status block
// assumes the host model on the serial pins and the bound checker
`timescale 1ns/1ps
module tb_actuator_ctrl_status;
    localparam int STARTUP = 1000;
    logic clock, srst, frame_select_low, serial_clock, serial_data_in, serial_data_out, serial_data_oe;
    logic ov, uv, trip, warn, one_on, six_on, status_clear, outputs_allowed, device_active;
    logic overload_retry_enable, overload_retry_duty;
    logic [16:0] switch_request;
    logic [23:0] control_word_one, rx, cw;
    actuator_ctrl_pkg::monitor_src_e current_monitor_source;
    int bad_count = 0;
    int comparisons = 0;
    actuator_ctrl_status #(.startup_cycles(STARTUP)) u_actuator_ctrl_status (.clock(clock), .srst(srst),
        .frame_select_low(frame_select_low), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .battery_over_voltage(ov),
        .battery_under_voltage(uv), .thermal_trip(trip), .thermal_warning(warn), .overload_flags(17'h00005),
        .status_word_one(24'h000000), .bridge_output_one_on(one_on), .bridge_output_six_on(six_on),
        .status_clear(status_clear), .control_word_one(control_word_one), .switch_request(switch_request),
        .outputs_allowed(outputs_allowed), .device_active(device_active), .overload_retry_enable(overload_retry_enable),
        .overload_retry_duty(overload_retry_duty), .current_monitor_source(current_monitor_source));
    spi_host_model u_spi_host_model (.clock(clock), .frame_select_low(frame_select_low),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));
    // core clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [23:0] mk(logic en, logic rs, logic du, logic rd, logic [1:0] mon);
        return {en, rs, du, rd, mon, 17'h00011, 1'b0};
    endfunction
    task automatic frame(input logic [23:0] tx, input int n = 24);
        u_spi_host_model.xfer(tx, n, rx);
    endtask
    task automatic t_start();
        cw = mk(1, 0, 0, 0, 2'b00);
        frame(cw);
        check(device_active, 1, "not active");
        frame(cw);
        check(rx[23], 1, "bit 23 low");
        check(rx[18], 1, "not ready missing");
        check(rx[17:0], 18'h0000b, "overload bits");
        check(outputs_allowed, 0, "early drive");
        for (int k = 0; k < STARTUP && outputs_allowed !== 1'b1; k++) @(posedge clock);
        repeat (2) @(posedge clock);
        check({outputs_allowed, switch_request}, {1'b1, 17'h00011}, "no drive after settle");
        frame(cw);
        check(rx[18], 0, "not ready stuck");
        $display("test start done");
    endtask
    task automatic t_monitor();
        actuator_ctrl_pkg::monitor_src_e ex [4];
        ex = '{actuator_ctrl_pkg::MON_ELEVEN, actuator_ctrl_pkg::MON_FIVE, actuator_ctrl_pkg::MON_FOUR,
            actuator_ctrl_pkg::MON_ONE};
        for (int k = 0; k < 4; k++) begin
            cw = mk(1, 0, k[0], 0, 2'(k ^ (k >> 1)));
            frame(cw);
            check(current_monitor_source, ex[k], "monitor source");
            check(overload_retry_duty, k[0], "retry duty");
        end
        six_on <= 1'b1;
        repeat (4) @(posedge clock);
        check(current_monitor_source, actuator_ctrl_pkg::MON_SIX, "six not chosen");
        $display("test monitor done");
    endtask
    task automatic t_faults();
        warn <= 1'b1;
        uv <= 1'b1;
        repeat (8) @(posedge clock);
        check(outputs_allowed, 0, "drive in undervoltage");
        frame(cw);
        check({rx[21], rx[19], rx[0]}, 3'b111, "uv or warning flag");
        uv <= 1'b0;
        repeat (8) @(posedge clock);
        check(outputs_allowed, 1, "no auto recovery or warning blocks");
        cw = mk(1, 0, 0, 1, 2'b00);
        frame(cw);
        ov <= 1'b1;
        trip <= 1'b1;
        repeat (8) @(posedge clock);
        ov <= 1'b0;
        trip <= 1'b0;
        warn <= 1'b0;
        repeat (8) @(posedge clock);
        check(outputs_allowed, 0, "recovered despite disable");
        frame(cw);
        check({rx[22], rx[20]}, 2'b11, "ov or trip flag");
        frame(mk(1, 1, 0, 1, 2'b00)); // host clears the flags
        check(outputs_allowed, 1, "clear did not restore");
        cw = mk(1, 0, 0, 0, 2'b00);
        frame(cw);
        check(rx[22:18], 5'h00, "flags not cleared");
        $display("test faults done");
    endtask
    task automatic t_word_one();
        frame(24'h250001);
        check(control_word_one, 24'h250001, "word one write");
        check(overload_retry_enable, 1, "retry enable");
        frame(24'h000000, 23);
        check(device_active, 1, "short frame taken");
        frame(24'h000000);
        check({device_active, outputs_allowed}, 2'b00, "standby not clean");
        check(control_word_one, 24'h000000, "word one not wiped");
        $display("test word one and standby done");
    endtask
    // watchdog well past the expected run of about eight thousand cycles
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        close_out();
    end
    // reset, then the scenarios in order
    initial begin
        {ov, uv, trip, warn, one_on, six_on} = 6'b000010;
        srst = 1'b1;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        check({device_active, outputs_allowed, serial_data_oe}, 3'b000, "reset state");
        t_start();
        t_monitor();
        t_faults();
        t_word_one();
        close_out();
    end
endmodule // tb_actuator_ctrl_status
